// ---- flash_ctl_pkg.sv ----
// package for the flash interface control block: register map, field layout, codes
// assumes a classic wishbone slave with 32-bit data and byte addressing
package flash_ctl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ACCESS_SIZE = 8'h00;
    localparam logic [7:0] ADDR_READ_WAIT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_SLOW_DOWN = 8'h0c;
    localparam logic [7:0] ADDR_SECURITY = 8'h10;

    // ------------------------------------------------------------
    // field codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] ASZ_PROG16 = 2'h1;
    localparam logic [1:0] ASZ_ROM32 = 2'h2;
    localparam logic [1:0] RWT_ZERO = 2'h0;
    localparam logic [1:0] RWT_TWO = 2'h2;
    localparam logic [2:0] SD_RESET = 3'h0;
    localparam int STAT_ECC_BIT = 2;
    localparam int STAT_HANG_BIT = 1;
    localparam int STAT_READY_BIT = 0;

    // ------------------------------------------------------------
    // security code location and protection value
    // ------------------------------------------------------------
    localparam logic [31:0] SECURITY_ADDR = 32'h0010_0000;
    localparam logic [15:0] PROTECT_CODE = 16'h0001;

    // flash-side access request from the cpu path, or from the external pins when ext is set
    typedef struct packed {
        logic valid;
        logic write;
        logic ext;
        logic [31:0] addr;
    } flash_req_s;

    // status inputs from the flash macro
    typedef struct packed {
        logic ecc_corrected;
        logic timing_limit_over;
        logic busy;
        logic chip_erase_done;
    } macro_stat_s;

endpackage

// ---- flash_interface_control.sv ----
// flash interface control: mode, wait control, status and security gating
// assumes classic wishbone on clk_i and a flash macro giving status levels
// ------------------------------------------------------------
// registers and read path
// ------------------------------------------------------------
module flash_interface_control
    import flash_ctl_pkg::*;
#(
    parameter int WAIT_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // flash access path
    input wire flash_req_s req_i,
    input wire logic [15:0] wdata_i,
    input wire macro_stat_s macro_i,
    output logic req_ready_o,
    output logic req_refused_o,
    output logic flash_access_o,
    output logic prog_mode_o,
    output logic protected_o
);
    initial begin
        if (WAIT_W < 4) $error("wait width too narrow");
    end

    logic [1:0] access_size_sel;
    logic [1:0] read_wait_cycles;
    logic [2:0] slow_down_wait;
    logic ecc_corrected_bit;
    logic hang_flag;
    logic ready_bit;
    // stored code power-up state is that of an erased array, so a first reset reads unprotected
    logic code_stored = 1'b0;
    logic erase_seen;
    logic protected_q;
    logic wb_req;
    logic wr_access;
    logic wr_rwait;
    logic wr_status;
    logic wr_slow;
    logic wait_done;
    logic wait_busy;
    logic read_start;
    logic [WAIT_W-1:0] total_waits;
    logic [31:0] next_dat;

    // added cycles of a slow-down code; prohibited codes never get stored
    function automatic logic [WAIT_W-1:0] sd_waits(input logic [2:0] code);
        sd_waits = WAIT_W'(code);
    endfunction

    // legal slow-down codes are zero and the odd ones
    function automatic logic sd_legal(input logic [2:0] code);
        sd_legal = (code == SD_RESET) || code[0];
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one-cycle ack; ack is dropped the cycle after it is given
    assign wb_req = cyc_i && stb_i && !ack_o;
    assign wr_access = wb_req && we_i && sel_i[0] && adr_i == ADDR_ACCESS_SIZE;
    assign wr_rwait = wb_req && we_i && sel_i[0] && adr_i == ADDR_READ_WAIT;
    assign wr_status = wb_req && we_i && sel_i[0] && adr_i == ADDR_STATUS;
    assign wr_slow = wb_req && we_i && sel_i[0] && adr_i == ADDR_SLOW_DOWN;

    // ack for every address; unmapped reads return zero, writes are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) ack_o <= 1'b0;
        else ack_o <= wb_req;
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // access size keeps its old value on a prohibited code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            access_size_sel <= ASZ_ROM32;
        end else if (wr_access) begin
            if (dat_i[1:0] == ASZ_PROG16 || dat_i[1:0] == ASZ_ROM32) begin
                access_size_sel <= dat_i[1:0];
            end
        end
    end

    // only bit 1 of read wait is storage; bit 0 is tied low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            read_wait_cycles <= RWT_TWO;
        end else if (wr_rwait) begin
            read_wait_cycles <= {dat_i[1], 1'b0};
        end
    end

    // slow-down register rejects the even nonzero codes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_down_wait <= SD_RESET;
        end else if (wr_slow && sd_legal(dat_i[2:0])) begin
            slow_down_wait <= dat_i[2:0];
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    // a correction in the clearing cycle wins, so no event is lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ecc_corrected_bit <= 1'b0;
        end else if (macro_i.ecc_corrected) begin
            ecc_corrected_bit <= 1'b1;
        end else if (wr_status && !dat_i[STAT_ECC_BIT]) begin
            ecc_corrected_bit <= 1'b0;
        end
    end

    // hang and ready follow the macro, registered for a clean read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hang_flag <= 1'b0;
            ready_bit <= 1'b1;
        end else begin
            hang_flag <= macro_i.timing_limit_over;
            ready_bit <= !macro_i.busy;
        end
    end

    // ------------------------------------------------------------
    // security
    // ------------------------------------------------------------
    // a code write or chip erase is only remembered here; it is applied at reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            erase_seen <= 1'b0;
        end else begin
            if (req_i.valid && req_i.write && req_ready_o && !req_refused_o
                && req_i.addr == SECURITY_ADDR && wdata_i == PROTECT_CODE) begin
                code_stored <= 1'b1;
            end
            if (macro_i.chip_erase_done) begin
                code_stored <= 1'b0;
                erase_seen <= 1'b1;
            end
        end
    end

    // protection only changes at reset, from what was stored before it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            protected_q <= code_stored;
        end
    end
    assign protected_o = protected_q;

    // ------------------------------------------------------------
    // flash access timing
    // ------------------------------------------------------------
    // rom mode waits read wait plus slow-down; programming mode takes none
    assign total_waits = (access_size_sel == ASZ_ROM32)
        ? WAIT_W'(read_wait_cycles) + sd_waits(slow_down_wait)
        : '0;

    // external pin access is refused outright while protected
    assign req_refused_o = req_i.valid && req_i.ext && protected_q;
    // rom mode is read only, and writes wait while the macro is busy
    assign read_start = req_i.valid && !req_i.write && !req_refused_o && !wait_busy;

    flash_wait_gen #(
        .CNT_W(WAIT_W)
    ) u_wait (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(read_start),
        .waits_i(total_waits),
        .done_o(wait_done),
        .busy_o(wait_busy)
    );

    // write needs programming mode and a ready macro
    always_comb begin
        if (!req_i.valid || req_refused_o) req_ready_o = req_refused_o;
        // raw busy is looked at too, since the registered ready bit lags the macro by a cycle
        else if (req_i.write) req_ready_o = (access_size_sel == ASZ_PROG16) && ready_bit && !macro_i.busy;
        else req_ready_o = wait_done;
    end
    assign flash_access_o = req_i.valid && !req_refused_o && req_ready_o;
    assign prog_mode_o = (access_size_sel == ASZ_PROG16);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // reserved status bits read as zero
    always_comb begin
        next_dat = '0;
        case (adr_i)
            ADDR_ACCESS_SIZE: next_dat[1:0] = access_size_sel;
            ADDR_READ_WAIT: next_dat[1:0] = read_wait_cycles;
            ADDR_STATUS: begin
                next_dat[STAT_ECC_BIT] = ecc_corrected_bit;
                next_dat[STAT_HANG_BIT] = hang_flag;
                next_dat[STAT_READY_BIT] = ready_bit;
            end
            ADDR_SLOW_DOWN: next_dat[2:0] = slow_down_wait;
            ADDR_SECURITY: next_dat[0] = protected_q;
            default: next_dat = '0;
        endcase
    end

    // data is registered together with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) dat_o <= '0;
        else if (wb_req && !we_i) dat_o <= next_dat;
    end

    // erase_seen is kept for visibility of an erase since reset
    logic unused_erase;
    assign unused_erase = erase_seen;
endmodule

// ---- flash_interface_control_monitor.sv ----
// checker for the flash interface control ports
// assumes one clock domain and a bind onto the top module
module flash_interface_control_monitor
    import flash_ctl_pkg::*;
#(
    parameter int WAIT_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire flash_req_s req_i,
    input wire logic [15:0] wdata_i,
    input wire macro_stat_s macro_i,
    input wire logic req_ready_o,
    input wire logic req_refused_o,
    input wire logic flash_access_o,
    input wire logic prog_mode_o,
    input wire logic protected_o
);
    // ----------------
    // properties
    // ----------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // accepted write of the programming code into the access size register
    sequence s_asz_prog;
        cyc_i && stb_i && we_i && ack_o && adr_i == ADDR_ACCESS_SIZE && sel_i[0] && dat_i[1:0] == ASZ_PROG16;
    endsequence
    sequence s_ext_req;
        req_i.valid && req_i.ext && protected_o;
    endsequence
    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    AST_RESET_MODE: assert property ($past(rst_i) |-> !prog_mode_o) else $error("not rom mode");
    AST_PROG_MODE: assert property (s_asz_prog |-> ##[1:2] prog_mode_o) else $error("no prog mode");
    AST_REFUSE_EXT: assert property (s_ext_req |-> req_refused_o && !flash_access_o) else $error("ext taken");
    AST_NO_REFUSE: assert property (!protected_o |-> !req_refused_o) else $error("bad refusal");
    AST_PROT_STABLE: assert property (!$past(rst_i) |-> $stable(protected_o)) else $error("prot moved");
    AST_ROM_WRITE_STALL: assert property (req_i.valid && req_i.write && !req_i.ext && !prog_mode_o
        |-> !req_ready_o) else $error("rom write done");
    AST_BUSY_WRITE: assert property (req_i.valid && req_i.write && !req_i.ext && macro_i.busy
        |-> !req_ready_o) else $error("write while busy");
endmodule

bind flash_interface_control flash_interface_control_monitor #(.WAIT_W(WAIT_W)) i_mon (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .req_i(req_i), .wdata_i(wdata_i),
    .macro_i(macro_i), .req_ready_o(req_ready_o), .req_refused_o(req_refused_o),
    .flash_access_o(flash_access_o), .prog_mode_o(prog_mode_o), .protected_o(protected_o));

// ---- flash_macro_model.sv ----
// behavioural flash macro status source
// assumes prog_start_i pulses for each accepted program write
module flash_macro_model
    import flash_ctl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic prog_start_i,
    input wire logic erase_i,
    input wire logic hang_i,
    input wire logic ecc_i,
    output macro_stat_s stat_o
);
    logic [3:0] busy_cnt;
    // a program write keeps the macro busy long enough to be seen on the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_cnt <= 4'h0;
        end else if (prog_start_i) begin
            busy_cnt <= 4'h8;
        end else if (busy_cnt != 4'h0) begin
            busy_cnt <= busy_cnt - 4'h1;
        end
    end
    // status levels and pulses as the macro reports them
    assign stat_o = '{ecc_i, hang_i, busy_cnt != 4'h0, erase_i};
endmodule

// ---- flash_wait_gen.sv ----
// wait generator: counts the inserted wait cycles of one flash read
// assumes start is a one-cycle pulse and nothing restarts it while busy
module flash_wait_gen
    import flash_ctl_pkg::*;
#(
    parameter int CNT_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [CNT_W-1:0] waits_i,
    output logic done_o,
    output logic busy_o
);
    initial begin
        if (CNT_W < 4) $error("wait counter too narrow for 2+7 waits");
    end

    logic [CNT_W-1:0] remaining;
    logic running;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // zero waits completes in the start cycle itself
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            remaining <= '0;
            running <= 1'b0;
        end else if (start_i && waits_i != '0) begin
            remaining <= waits_i;
            running <= 1'b1;
        end else if (running) begin
            remaining <= remaining - 1'b1;
            if (remaining == CNT_W'(1)) running <= 1'b0;
        end
    end

    assign done_o = (start_i && waits_i == '0) || (running && remaining == CNT_W'(1));
    assign busy_o = running;
endmodule

// ---- tb_flash_interface_control.sv ----
// testbench for the flash interface control block
// assumes the macro model and the bound checker
module tb_flash_interface_control import flash_ctl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, rdy, rf, acc, pm, prot;
    logic erase = 0, hang = 0, ecc = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rd, q;
    logic [15:0] hw = 16'h0;
    flash_req_s req = '0;
    macro_stat_s ms;
    int n_mismatch = 0, total_checks = 0, n;
    flash_interface_control #(.WAIT_W(4)) i_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wd), .dat_o(rd), .ack_o(ack), .req_i(req),
        .wdata_i(hw), .macro_i(ms), .req_ready_o(rdy), .req_refused_o(rf), .flash_access_o(acc),
        .prog_mode_o(pm), .protected_o(prot));
    flash_macro_model i_macro (.clk_i(clk), .rst_i(rst), .prog_start_i(acc && req.write),
        .erase_i(erase), .hang_i(hang), .ecc_i(ecc), .stat_o(ms));
    initial begin
        forever #5 clk = ~clk;
    end
    // ----------------
    // shared tasks
    // ----------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        for (i = 0; i < 20 && ack !== 1'b1; i++) begin
            @(posedge clk);
        end
        q = rd;
        {cyc, stb, we} <= 3'b000;
        if (i == 20) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    // flash request held until ready; n counts the inserted waits
    task automatic freq(input logic w, input logic x, input logic [31:0] a);
        @(posedge clk);
        req <= '{1'b1, w, x, a};
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (rdy === 1'b1) break;
        end
        req <= '0;
        if (n == 40) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_regs;
        logic [2:0] prev;
        rd_chk(ADDR_ACCESS_SIZE, 32'(ASZ_ROM32));
        rd_chk(ADDR_READ_WAIT, 32'(RWT_TWO));
        rd_chk(ADDR_SLOW_DOWN, 32'(SD_RESET));
        rd_chk(8'h40, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, ADDR_ACCESS_SIZE, 32'(8'hb1 >> (2 * i)) & 32'h3);
            rd_chk(ADDR_ACCESS_SIZE, 32'(8'h95 >> (2 * i)) & 32'h3);
            if (i == 0) check(32'(pm), 32'h1);
            wb(1'b1, ADDR_READ_WAIT, 32'(i));
            rd_chk(ADDR_READ_WAIT, 32'(i) & 32'h2);
        end
        prev = 3'h0;
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, ADDR_SLOW_DOWN, 32'(i));
            if (i == 0 || i % 2 == 1) prev = 3'(i);
            rd_chk(ADDR_SLOW_DOWN, 32'(prev));
        end
    endtask
    // rom reads wait read wait plus slow-down cycles; rom writes stall
    task automatic t_wait;
        freq(1'b0, 1'b0, 32'h100);
        check(32'(n), 32'd9);
        wb(1'b1, ADDR_READ_WAIT, 32'(RWT_ZERO));
        wb(1'b1, ADDR_SLOW_DOWN, 32'h3);
        freq(1'b0, 1'b0, 32'h100);
        check(32'(n), 32'd3);
        @(posedge clk);
        req <= '{1'b1, 1'b1, 1'b0, 32'h100};
        repeat (3) @(posedge clk);
        check(32'(rdy), 32'h0);
        req <= '0;
    endtask
    task automatic t_status;
        rd_chk(ADDR_STATUS, 32'h1);
        hang <= 1'b1;
        rd_chk(ADDR_STATUS, 32'h3);
        hang <= 1'b0;
        ecc <= 1'b1;
        @(posedge clk);
        ecc <= 1'b0;
        wb(1'b1, ADDR_STATUS, 32'hfc);
        rd_chk(ADDR_STATUS, 32'h5);
        wb(1'b1, ADDR_STATUS, 32'h0);
        rd_chk(ADDR_STATUS, 32'h1);
    endtask
    // protection takes hold and lifts only across a reset
    task automatic t_secure;
        wb(1'b1, ADDR_ACCESS_SIZE, 32'(ASZ_PROG16));
        rd_chk(ADDR_ACCESS_SIZE, 32'(ASZ_PROG16));
        hw <= PROTECT_CODE;
        freq(1'b1, 1'b0, SECURITY_ADDR);
        rd_chk(ADDR_STATUS, 32'h0);
        repeat (10) @(posedge clk);
        rd_chk(ADDR_STATUS, 32'h1);
        check(32'(prot), 32'h0);
        do_reset();
        check(32'(prot), 32'h1);
        freq(1'b0, 1'b1, 32'h100);
        check(32'(rf), 32'h1);
        erase <= 1'b1;
        @(posedge clk);
        erase <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'(prot), 32'h1);
        do_reset();
        check(32'(prot), 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_wait();
        t_status();
        t_secure();
        conclude();
    end
endmodule
